// file: core/cfg_loader_pkg.sv
// Constants shared by the configuration shadow loader files
// What the document requires of the block and of those who program and build for it
// [RQ1] At power-up the nonvolatile configuration words are copied into volatile shadow storage.
// [RQ2] Every device reset, whatever its source, reloads all shadow registers from the stored words.
// [RQ3] The 12-bit boot sequence number picks the active Flash panel, and only its words load.
// [RQ4] Fetching an instruction for execution from configuration space resets the device.
// [RQ5] A page erase of the final program memory page erases the stored configuration words.
// [RQ6] In dual-partition mode the inactive panel's words govern access to the inactive panel.
// [RQ7] Words sit at the top of memory: 0x02BF00 single, 0x015F00 active, 0x415F00 inactive.
// [RQ8] The boot mode word sits at 0x801800 in calibration space for every size and mode.
// [RQ9] Every unimplemented bit of a configuration register reads as one.
// [RQ10] Whoever programs the words keeps each reserved bit at its specified one or zero value.
// [RQ11] Application builds should reserve the configuration locations so no code lands there.
// [RQ12] Shadow values stay stable until the next reload, and the device leaves reset after it.
package cfg_loader_pkg;
  localparam int          CFG_WORD_W   = 24;
  localparam int          AXI_ADDR_W   = 24;
  localparam int          NUM_CFG      = 17;
  localparam int          NUM_PANEL    = 16;
  localparam int          IDX_W        = 5;
  localparam logic [4:0]  IDX_PROTECT  = 5'h00;
  localparam logic [4:0]  IDX_BTSEQ    = 5'h0F;
  localparam logic [4:0]  IDX_BOOT     = 5'h10;
  localparam logic [4:0]  LAST_PANEL   = 5'h0F;
  // Layout bases; low byte is always zero so only the page part is swapped
  localparam logic [23:0] SINGLE_BASE        = 24'h02BF00;
  localparam logic [23:0] DUAL_ACTIVE_BASE   = 24'h015F00;
  localparam logic [23:0] DUAL_INACTIVE_BASE = 24'h415F00;
  localparam logic [23:0] BOOT_MODE_ADDR     = 24'h801800;
  localparam logic [23:0] STATUS_OFS         = 24'h02BF80;
  localparam logic [23:0] CONTROL_OFS        = 24'h02BF84;
  localparam logic [23:0] CFG_OFS [NUM_CFG] = '{
    24'h02BF00, 24'h02BF10, 24'h02BF14, 24'h02BF18, 24'h02BF1C, 24'h02BF20,
    24'h02BF24, 24'h02BF28, 24'h02BF2C, 24'h02BF30, 24'h02BF34, 24'h02BF38,
    24'h02BF3C, 24'h02BF40, 24'h02BF44, 24'h02BFFC, 24'h801800};
  // Implemented (or reserved) bit positions; all others read as one
  localparam logic [23:0] CFG_IMPL_MASK [NUM_CFG] = '{
    24'h008FEF, 24'h001FFF, 24'h008000, 24'h000087, 24'h001DC7, 24'h00FFFF,
    24'h000470, 24'h0080A3, 24'h00FFFF, 24'h00FFFF, 24'h00FFFF, 24'h00FFFF,
    24'h000001, 24'h0027BC, 24'h007777, 24'hFFFFFF, 24'h000003};
  localparam logic [23:0] ALL_ONES     = 24'hFFFFFF;
  // Boot sequence and boot mode fields
  localparam int          SEQ_NUM_LSB  = 0;
  localparam int          SEQ_NUM_W    = 12;
  localparam int          SEQ_INV_LSB  = 12;
  localparam int          BOOT_MODE_W  = 2;
  // Status and control bits
  localparam int          ST_DONE      = 0;
  localparam int          ST_PANEL     = 1;
  localparam int          ST_DUAL      = 2;
  localparam int          ST_ERASED    = 3;
  localparam int          ST_EXEC      = 4;
  localparam int          CTRL_RELOAD  = 0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [1:0]  SYNC_RST_VAL = 2'h1;
endpackage

// file: core/pin_sync.sv
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int         W       = 2,
  parameter logic [1:0] RST_VAL = 2'h0
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  wire  [W-1:0] rst_lvl = W'(RST_VAL);

  // Chain runs through reset so straps are settled when the load starts;
  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    s1 <= pin_in;
    s2 <= s1;
    s3 <= s2;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        pin_out[i] <= s3[i];
      end else if (!aresetn) begin
        pin_out[i] <= rst_lvl[i];
      end
    end
  end
endmodule
`default_nettype wire

// file: core/config_shadow_mem.sv
// Shadow storage for the loaded configuration words
`timescale 1ns/1ps
`default_nettype none
module config_shadow_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 17,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Write port from the loader
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Registered read port
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= '0;
    end else if (rd_en && (int'(rd_addr) < DEPTH)) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// file: core/config_word_shadow_loader.sv
// Configuration word loader with AXI4-Lite view of the shadow registers
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module config_word_shadow_loader #(
  parameter int N_RST_REQ = 4,
  parameter int PAGE_BITS = 11
) (
  // Clock and reset
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  // AXI4-Lite write
  input  wire logic [cfg_loader_pkg::AXI_ADDR_W-1:0] awaddr,
  input  wire logic                                  awvalid,
  output logic                                       awready,
  input  wire logic [31:0]                           wdata,
  input  wire logic [3:0]                            wstrb,
  input  wire logic                                  wvalid,
  output logic                                       wready,
  output logic [1:0]                                 bresp,
  output logic                                       bvalid,
  input  wire logic                                  bready,
  // AXI4-Lite read
  input  wire logic [cfg_loader_pkg::AXI_ADDR_W-1:0] araddr,
  input  wire logic                                  arvalid,
  output logic                                       arready,
  output logic [31:0]                                rdata,
  output logic [1:0]                                 rresp,
  output logic                                       rvalid,
  input  wire logic                                  rready,
  // Flash read port
  output logic                                       flash_rd_req,
  output logic [23:0]                                flash_rd_addr,
  input  wire logic                                  flash_rd_ack,
  input  wire logic [cfg_loader_pkg::CFG_WORD_W-1:0] flash_rd_data,
  // Reset sources and pins
  input  wire logic                                  ext_reset_pin_n,
  input  wire logic                                  dual_partition_strap,
  input  wire logic [N_RST_REQ-1:0]                  reset_req,
  // Instruction fetch and page erase monitors
  input  wire logic                                  fetch_valid,
  input  wire logic [23:0]                           fetch_addr,
  input  wire logic                                  page_erase_req,
  input  wire logic [23:0]                           page_erase_addr,
  // Device side
  output logic                                       sys_reset_n,
  output logic                                       flash_cfg_erase,
  output logic                                       active_panel,
  output logic [cfg_loader_pkg::BOOT_MODE_W-1:0]     boot_mode_field,
  output logic [cfg_loader_pkg::CFG_WORD_W-1:0]      active_protect,
  output logic [cfg_loader_pkg::CFG_WORD_W-1:0]      inactive_protect
);
  import cfg_loader_pkg::*;

  typedef enum logic [2:0] {
    st_reset, st_seq0, st_seq1, st_load, st_boot, st_inact, st_run
  } load_state_e;

  load_state_e state;
  load_state_e next_state;
  logic [IDX_W-1:0]      load_idx;
  logic                  dual_mode;
  logic [CFG_WORD_W-1:0] seq0_word;
  logic                  reload_pend;
  logic                  erased_seen;
  logic                  exec_seen;
  logic                  load_done;
  logic [1:0]            pins_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  pin_sync #(.W(2), .RST_VAL(SYNC_RST_VAL)) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  ({dual_partition_strap, ext_reset_pin_n}),
    .pin_out (pins_sync)
  );

  wire pin_reset_held = !pins_sync[0];
  wire strap_dual     = pins_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Address windows
  wire [15:0] active_page   = dual_mode ? DUAL_ACTIVE_BASE[23:8] : SINGLE_BASE[23:8];
  wire [15:0] inactive_page = DUAL_INACTIVE_BASE[23:8];
  wire exec_hit = fetch_valid && ((fetch_addr[23:8] == active_page)
                  || (dual_mode && fetch_addr[23:8] == inactive_page));
  wire [23:0] active_base = {active_page, 8'h00};
  wire erase_hit = page_erase_req
                   && ((page_erase_addr[23:PAGE_BITS] == active_base[23:PAGE_BITS])
                   || (dual_mode
                   && page_erase_addr[23:PAGE_BITS] == DUAL_INACTIVE_BASE[23:PAGE_BITS]));

  ////////////////////////////////////////////////////////////////////////////////
  // Boot sequence choice
  wire [SEQ_NUM_W-1:0] seq0_num = seq0_word[SEQ_NUM_LSB +: SEQ_NUM_W];
  wire [SEQ_NUM_W-1:0] seq1_num = flash_rd_data[SEQ_NUM_LSB +: SEQ_NUM_W];
  wire seq0_ok = seq0_word[SEQ_INV_LSB +: SEQ_NUM_W] == ~seq0_num;
  wire seq1_ok = flash_rd_data[SEQ_INV_LSB +: SEQ_NUM_W] == ~seq1_num;
  // Lower valid number wins; a blank panel never beats a valid one
  wire panel1_wins = seq1_ok && (!seq0_ok || (seq1_num < seq0_num));

  ////////////////////////////////////////////////////////////////////////////////
  // Reload triggers
  logic sw_reload;
  wire  rst_trig = pin_reset_held || (|reset_req) || sw_reload
                   || (sys_reset_n && exec_hit); // see [RQ2] see [RQ4]
  // A trigger on the final ack would otherwise be lost
  wire  reload_due = reload_pend || rst_trig;

  ////////////////////////////////////////////////////////////////////////////////
  // Load sequencer
  always_comb begin
    next_state = state;
    case (state)
      st_reset: begin
        if (!pin_reset_held) begin
          next_state = strap_dual ? st_seq0 : st_load;
        end
      end
      st_seq0: begin
        if (flash_rd_ack) begin
          next_state = st_seq1;
        end
      end
      st_seq1: begin
        if (flash_rd_ack) begin
          next_state = st_load;
        end
      end
      st_load: begin
        if (flash_rd_ack && load_idx == LAST_PANEL) begin
          next_state = st_boot;
        end
      end
      st_boot: begin
        if (flash_rd_ack) begin
          next_state = dual_mode ? st_inact : (reload_due ? st_reset : st_run);
        end
      end
      st_inact: begin
        if (flash_rd_ack) begin
          next_state = reload_due ? st_reset : st_run;
        end
      end
      st_run: begin
        if (rst_trig) begin
          next_state = st_reset; // see [RQ2]
        end
      end
      default: next_state = st_reset;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= st_reset; // see [RQ1]
      sys_reset_n <= 1'b0;
    end else begin
      state       <= next_state;
      sys_reset_n <= (next_state == st_run); // see [RQ12]
    end
  end

  // A reset arriving mid-load restarts the load once this one ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_pend <= 1'b0;
    end else if (state != st_run && state != st_reset && rst_trig) begin
      reload_pend <= 1'b1;
    end else if (state == st_reset) begin
      reload_pend <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_idx  <= '0;
      dual_mode <= 1'b0;
      seq0_word <= '0;
    end else begin
      if (state == st_reset) begin
        load_idx  <= '0;
        dual_mode <= strap_dual;
      end else if (state == st_load && flash_rd_ack) begin
        load_idx <= load_idx + 5'h01;
      end
      if (state == st_seq0 && flash_rd_ack) begin
        seq0_word <= flash_rd_data;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_panel <= 1'b0;
    end else if (state == st_reset) begin
      active_panel <= 1'b0;
    end else if (state == st_seq1 && flash_rd_ack) begin
      active_panel <= panel1_wins; // see [RQ3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flash request
  wire        read_panel = (state == st_seq1) || (state == st_inact && !active_panel)
                           || (state == st_load && active_panel);
  wire [15:0] read_page  = !dual_mode && state != st_seq0 && state != st_seq1 ? SINGLE_BASE[23:8]
                           : (read_panel ? DUAL_INACTIVE_BASE[23:8] : DUAL_ACTIVE_BASE[23:8]);
  wire [7:0]  read_ofs   = (state == st_load) ? CFG_OFS[load_idx][7:0]
                           : (state == st_inact) ? CFG_OFS[IDX_PROTECT][7:0]
                           : CFG_OFS[IDX_BTSEQ][7:0];

  assign flash_rd_req  = (state != st_reset) && (state != st_run);
  assign flash_rd_addr = (state == st_boot) ? BOOT_MODE_ADDR : {read_page, read_ofs}; // see [RQ7] see [RQ8]

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow storage and captured copies
  wire              mem_wr  = flash_rd_ack && (state == st_load || state == st_boot); // see [RQ1]
  wire [IDX_W-1:0]  mem_wa  = (state == st_boot) ? IDX_BOOT : load_idx;
  logic             mem_rd;
  logic [IDX_W-1:0] mem_ra;
  logic [CFG_WORD_W-1:0] mem_rdata;

  config_shadow_mem #(.WIDTH(CFG_WORD_W), .DEPTH(NUM_CFG), .AW(IDX_W)) u_shadow (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (mem_wr),
    .wr_addr (mem_wa),
    .wr_data (flash_rd_data),
    .rd_en   (mem_rd),
    .rd_addr (mem_ra),
    .rd_data (mem_rdata)
  );

  // Copies change only while the device is held in reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_protect   <= ALL_ONES;
      inactive_protect <= ALL_ONES;
      boot_mode_field  <= '1;
    end else begin
      if (state == st_load && flash_rd_ack && load_idx == IDX_PROTECT) begin
        active_protect <= flash_rd_data; // see [RQ12]
      end
      if (state == st_boot && flash_rd_ack) begin
        boot_mode_field <= flash_rd_data[BOOT_MODE_W-1:0];
      end
      if (state == st_reset) begin
        inactive_protect <= ALL_ONES;
      end else if (state == st_inact && flash_rd_ack) begin
        inactive_protect <= flash_rd_data; // see [RQ6]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_cfg_erase <= 1'b0;
      erased_seen     <= 1'b0;
      exec_seen       <= 1'b0;
      load_done       <= 1'b0;
    end else begin
      flash_cfg_erase <= erase_hit; // see [RQ5]
      if (erase_hit) begin
        erased_seen <= 1'b1;
      end
      if (sys_reset_n && exec_hit) begin
        exec_seen <= 1'b1;
      end
      load_done <= (next_state == st_run);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite decode
  logic [NUM_CFG-1:0] ar_hit;
  logic [NUM_CFG-1:0] aw_hit;
  logic [IDX_W-1:0]   ar_idx;
  logic               aw_got;
  logic               w_got;
  logic [23:0]        aw_addr_q;
  logic [31:0]        w_data_q;
  logic [3:0]         w_strb_q;

  for (genvar g = 0; g < NUM_CFG; g++) begin : g_dec
    assign ar_hit[g] = (araddr == CFG_OFS[g]);
    assign aw_hit[g] = (aw_addr_q == CFG_OFS[g]);
  end

  always_comb begin
    ar_idx = '0;
    for (int i = 0; i < NUM_CFG; i++) begin
      if (ar_hit[i]) begin
        ar_idx = IDX_W'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign awready = !aw_got && !bvalid;
  assign wready  = !w_got && !bvalid;
  wire wr_do     = aw_got && w_got && !bvalid;
  wire wr_ctrl   = aw_addr_q == CONTROL_OFS;
  wire wr_mapped = wr_ctrl || (|aw_hit) || aw_addr_q == STATUS_OFS;
  assign sw_reload = wr_do && wr_ctrl && w_strb_q[0] && w_data_q[CTRL_RELOAD];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got    <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got    <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_do) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic        rd_busy;
  logic        rd_cfg;
  logic        rd_stat;
  logic        rd_ctrl;
  logic [23:0] rd_mask;
  wire  [31:0] status_word = {27'h0, exec_seen, erased_seen, dual_mode, active_panel, load_done};

  assign arready = !rd_busy && !rvalid;
  assign mem_rd  = arvalid && arready;
  assign mem_ra  = ar_idx;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_busy <= 1'b0;
      rd_cfg  <= 1'b0;
      rd_stat <= 1'b0;
      rd_ctrl <= 1'b0;
      rd_mask <= '0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      if (mem_rd) begin
        rd_busy <= 1'b1;
        rd_cfg  <= |ar_hit;
        rd_stat <= araddr == STATUS_OFS;
        rd_ctrl <= araddr == CONTROL_OFS;
        rd_mask <= CFG_IMPL_MASK[ar_idx];
      end
      if (rd_busy) begin
        rd_busy <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= (rd_cfg || rd_stat || rd_ctrl) ? RESP_OKAY : RESP_SLVERR;
        rdata   <= rd_cfg ? {8'h00, mem_rdata | ~rd_mask} // see [RQ9] see [RQ10]
                   : (rd_stat ? status_word : 32'h0);
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [IDX_W-1:0] words_loaded;
  always_ff @(posedge aclk) begin
    if (!aresetn || state == st_reset) begin
      words_loaded <= '0;
    end else if (mem_wr) begin
      words_loaded <= words_loaded + 5'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_full_load;
    $rose(sys_reset_n) |-> words_loaded == 5'h11 && load_done;
  endproperty
  a_full_load: assert property (p_full_load) else $error("released before full load"); // see [RQ1]
  property p_reset_reload;
    sys_reset_n && (|reset_req) |=> !sys_reset_n ##1 state == st_reset || state != st_run;
  endproperty
  a_reset_reload: assert property (p_reset_reload) else $error("reset did not reload"); // see [RQ2]
  property p_panel_choice;
    state == st_seq1 && flash_rd_ack |=> active_panel == $past(panel1_wins);
  endproperty
  a_panel_choice: assert property (p_panel_choice) else $error("wrong active panel"); // see [RQ3]
  property p_exec_reset;
    sys_reset_n && exec_hit |=> !sys_reset_n && exec_seen;
  endproperty
  a_exec_reset: assert property (p_exec_reset) else $error("config fetch not reset"); // see [RQ4]
  property p_erase;
    erase_hit |=> flash_cfg_erase && erased_seen;
  endproperty
  a_erase: assert property (p_erase) else $error("last page erase missed"); // see [RQ5]
  property p_inactive;
    state == st_inact && flash_rd_ack |=> inactive_protect == $past(flash_rd_data);
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive word not kept"); // see [RQ6]
  property p_single_base;
    state == st_load && !dual_mode && load_idx == 5'h00 |-> flash_rd_addr == 24'h02BF00;
  endproperty
  a_single_base: assert property (p_single_base) else $error("bad config base"); // see [RQ7]
  property p_boot_addr;
    state == st_boot |-> flash_rd_addr == 24'h801800 && flash_rd_req;
  endproperty
  a_boot_addr: assert property (p_boot_addr) else $error("bad boot mode address"); // see [RQ8]
  property p_unimpl_ones;
    rvalid && $rose(rvalid) && rd_cfg |-> (rdata[23:0] | rd_mask) == 24'hFFFFFF;
  endproperty
  a_unimpl_ones: assert property (p_unimpl_ones) else $error("unimplemented bit not one"); // see [RQ9]
  property p_stable;
    sys_reset_n && $past(sys_reset_n) |-> $stable(active_protect) && $stable(boot_mode_field);
  endproperty
  a_stable: assert property (p_stable) else $error("shadow changed while running"); // see [RQ12]

  c_dual_load: cover property (state == st_inact && flash_rd_ack);
  c_panel1: cover property ($rose(active_panel));
  c_exec: cover property (sys_reset_n && exec_hit);
  c_sw_reload: cover property (sw_reload && state == st_run);
endmodule
`default_nettype wire

// file: test/flash_model.sv
// Behavioural configuration flash with its image function
`timescale 1ns/1ps
`default_nettype none
package flash_img_pkg;
  // Image word per address; keeps the boot sequence pairs consistent
  function automatic logic [23:0] fw(input logic [23:0] a);
    logic [23:0] d;
    d = {a[7:0] ^ 8'hC3, a[15:0] ^ 16'h5A96};
    if (a[7:0] == 8'hFC) d = a[22] ? {~12'h003, 12'h003} : {~12'h005, 12'h005};
    if (a[7:0] == 8'h14) d[15] = 1'b0;
    return d;
  endfunction
endpackage
module flash_model (
  // Clock
  input  wire logic        aclk,
  // Read port
  input  wire logic        flash_rd_req,
  input  wire logic [23:0] flash_rd_addr,
  output logic             flash_rd_ack,
  output logic [23:0]      flash_rd_data
);
  import flash_img_pkg::*;
  logic [1:0]  wait_cnt = 2'h0;
  logic [23:0] word     = 24'h000000;
  initial flash_rd_ack = 1'b0;
  // Stall depends on address, so prompt and slow answers both occur
  always @(posedge aclk) begin
    flash_rd_ack <= 1'b0;
    wait_cnt <= 2'h0;
    if (flash_rd_req && !flash_rd_ack) begin
      if (wait_cnt == flash_rd_addr[3:2]) begin
        flash_rd_ack <= 1'b1;
        word <= fw(flash_rd_addr);
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
  // No stale word outside the ack cycle
  assign flash_rd_data = flash_rd_ack ? word : ~word;
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the configuration shadow loader
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
  import cfg_loader_pkg::*;
  import flash_img_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic ext_reset_pin_n = 1, dual_partition_strap = 0, fetch_valid = 0, page_erase_req = 0;
  logic [23:0] awaddr = '0, araddr = '0, fetch_addr = '0, page_erase_addr = '0, bw;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hF, reset_req = 4'h0;
  logic [1:0]  bresp, rresp, boot_mode_field, exp_b, wq[$];
  logic [33:0] exp_r, rq[$];
  logic awready, wready, bvalid, arready, rvalid, flash_rd_req, flash_rd_ack;
  logic sys_reset_n, flash_cfg_erase, active_panel;
  logic [23:0] flash_rd_addr, flash_rd_data, active_protect, inactive_protect;
  int compares = 0, miscompares = 0, n;
  integer seed = 32'h1DA8;
  always #25 aclk = ~aclk;
  config_word_shadow_loader u_config_word_shadow_loader (.*);
  flash_model u_flash_model (.*);
  // Scoreboard: oldest note against each response
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      exp_b = wq.pop_front();
      `CK("bresp", exp_b, bresp)
    end
    if (rvalid && rready) begin
      exp_r = rq.pop_front();
      `CK("read", exp_r, {rresp, rdata})
    end
  end
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge aclk);
    wq.push_back(RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask
  task automatic rd(input logic [23:0] a, input logic [33:0] e);
    @(posedge aclk);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) rready <= 1'b0;
    end while (arvalid || rready);
  endtask
  function automatic logic [33:0] ce(int i, logic [23:0] a);
    return {RESP_OKAY, 8'h00, fw(a) | ~CFG_IMPL_MASK[i]};
  endfunction
  task automatic wait_lvl(input logic v, input int lim);
    n = 0;
    while (sys_reset_n !== v && n < lim) begin @(posedge aclk); n++; end
    `CK("sys_reset_n", v, sys_reset_n)
  endtask
  task automatic check_all(input logic [23:0] base);
    for (int i = 0; i < NUM_CFG - 1; i++) rd(CFG_OFS[i], ce(i, base + CFG_OFS[i][7:0]));
    rd(BOOT_MODE_ADDR, ce(16, BOOT_MODE_ADDR));
  endtask
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wait_lvl(1'b1, 400);
    check_all(SINGLE_BASE);
    bw = fw(BOOT_MODE_ADDR);
    `CK("boot_mode_field", bw[1:0], boot_mode_field)
    `CK("active_protect", fw(SINGLE_BASE), active_protect)
    `CK("inactive_protect", 24'hFFFFFF, inactive_protect)
    rd(STATUS_OFS, {RESP_OKAY, 32'h00000001});
    rd(24'h02BF04, {RESP_SLVERR, 32'h00000000});
    wr(CFG_OFS[5], $random(seed));
    rd(CFG_OFS[5], ce(5, CFG_OFS[5]));
    $display("test load done");
    reset_req <= 4'h1 << ($unsigned($random(seed)) % 4);
    @(posedge aclk);
    reset_req <= 4'h0;
    wait_lvl(1'b0, 4);
    wait_lvl(1'b1, 400);
    wr(CONTROL_OFS, 32'h00000001);
    wait_lvl(1'b0, 4);
    wait_lvl(1'b1, 400);
    ext_reset_pin_n <= 1'b0;
    wait_lvl(1'b0, 12);
    ext_reset_pin_n <= 1'b1;
    wait_lvl(1'b1, 400);
    check_all(SINGLE_BASE);
    $display("test reset sources done");
    fetch_valid <= 1'b1;
    fetch_addr <= CFG_OFS[3];
    @(posedge aclk);
    fetch_valid <= 1'b0;
    wait_lvl(1'b0, 4);
    wait_lvl(1'b1, 400);
    page_erase_req <= 1'b1;
    page_erase_addr <= SINGLE_BASE + 24'h000040;
    @(posedge aclk);
    page_erase_req <= 1'b0;
    n = 0;
    while (flash_cfg_erase !== 1'b1 && n < 4) begin @(posedge aclk); n++; end
    `CK("flash_cfg_erase", 1'b1, flash_cfg_erase)
    rd(STATUS_OFS, {RESP_OKAY, 32'h00000019});
    $display("test fetch and erase done");
    dual_partition_strap <= 1'b1;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wait_lvl(1'b1, 400);
    `CK("active_panel", 1'b1, active_panel)
    `CK("inactive_protect", fw(DUAL_ACTIVE_BASE), inactive_protect)
    `CK("active_protect", fw(DUAL_INACTIVE_BASE), active_protect)
    check_all(DUAL_INACTIVE_BASE);
    rd(STATUS_OFS, {RESP_OKAY, 32'h00000007});
    $display("test dual partition done");
    close_out();
  end
endmodule
`default_nettype wire
